/* logic/rvm_vector_map.sv */
// Reset and interrupt vector address generator facing the core's instruction fetch
//
// Summary of operation
// - Reset fetches word 0x000 unless relocated
// - External requests zero, one at 0x001, 0x002
// - Pin-change groups 0x003-0x005, watchdog 0x006
// - Timer 2 compares, overflow at 0x007-0x009
// - Timer 1 capture, compares, overflow 0x00A-0x00D
// - Timer 0 compares, overflow at 0x00E-0x010
// - Serial transfer 0x011, receive complete 0x012
// - Transmit empty 0x013, transmit complete 0x014
// - Converter, data memory, comparator, two-wire, store
// - Two-word slots in larger variants, else one
// - Smallest variant never relocates reset or table
// - Fuse picks reset address, bit picks table
// - Relocated vector is boot start plus slot
`timescale 1ns/100ps
`default_nettype none
module rvm_vector_map
   import rvm_pkg::*;
#(
   parameter logic [1:0] VARIANT = RVM_VAR_LARGEST
)
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        external_request_zero,
   input  wire logic        external_request_one,
   input  wire logic        pin_change_group_zero,
   input  wire logic        pin_change_group_one,
   input  wire logic        pin_change_group_two,
   input  wire logic        watchdog_timeout_source,
   input  wire logic        timer2_compare_a,
   input  wire logic        timer2_compare_b,
   input  wire logic        timer2_overflow,
   input  wire logic        timer1_capture,
   input  wire logic        timer1_compare_a,
   input  wire logic        timer1_compare_b,
   input  wire logic        timer1_overflow,
   input  wire logic        timer0_compare_a,
   input  wire logic        timer0_compare_b,
   input  wire logic        timer0_overflow,
   input  wire logic        serial_transfer_done,
   input  wire logic        usart_rx_done,
   input  wire logic        usart_tx_empty,
   input  wire logic        usart_tx_done,
   input  wire logic        converter_done,
   input  wire logic        data_nvm_ready_source,
   input  wire logic        comparator_event,
   input  wire logic        two_wire_serial_source,
   input  wire logic        program_store_ready_source,
   input  wire logic        cpu_int_enable,
   input  wire logic        vector_table_select_bit,
   input  wire logic        boot_reset_select_fuse,
   input  wire logic [13:0] boot_section_start,
   input  wire logic        fetch_ready,
   output logic             fetch_valid,
   output logic [13:0]      fetch_addr_q,
   output logic [4:0]       vector_number_q,
   output logic [24:0]      serviced_q
);

   rvm_state_e  state_q;
   rvm_state_e  state_d;
   logic [13:0] fetch_addr_d;
   logic [4:0]  vector_number_d;
   logic [24:0] serviced_d;
   logic [24:0] req_w;
   logic        any_w;
   logic [4:0]  win_num_w;
   logic        has_boot_w;
   logic        wide_w;
   logic        boot_reset_w;
   logic        reloc_w;
   logic        take_w;
   logic        done_w;
   logic [13:0] reset_addr_w;
   logic [13:0] irq_addr_w;

   // Bit n-1 of the request word belongs to table position n
   assign req_w[0]  = external_request_zero;
   assign req_w[1]  = external_request_one;
   assign req_w[2]  = pin_change_group_zero;
   assign req_w[3]  = pin_change_group_one;
   assign req_w[4]  = pin_change_group_two;
   assign req_w[5]  = watchdog_timeout_source;
   assign req_w[6]  = timer2_compare_a;
   assign req_w[7]  = timer2_compare_b;
   assign req_w[8]  = timer2_overflow;
   assign req_w[9]  = timer1_capture;
   assign req_w[10] = timer1_compare_a;
   assign req_w[11] = timer1_compare_b;
   assign req_w[12] = timer1_overflow;
   assign req_w[13] = timer0_compare_a;
   assign req_w[14] = timer0_compare_b;
   assign req_w[15] = timer0_overflow;
   assign req_w[16] = serial_transfer_done;
   assign req_w[17] = usart_rx_done;
   assign req_w[18] = usart_tx_empty;
   assign req_w[19] = usart_tx_done;
   assign req_w[20] = converter_done;
   assign req_w[21] = data_nvm_ready_source;
   assign req_w[22] = comparator_event;
   assign req_w[23] = two_wire_serial_source;
   assign req_w[24] = program_store_ready_source;

   rvm_prio_enc u_prio (
      .req (req_w),
      .any (any_w),
      .num (win_num_w)
   );

   // Variant shapes the map at build time
   assign has_boot_w   = (VARIANT != RVM_VAR_SMALL);
   assign wide_w       = (VARIANT >= RVM_VAR_WIDE_MIN);
   assign boot_reset_w = has_boot_w && (boot_reset_select_fuse == RVM_FUSE_PROGRAMMED);
   assign reloc_w      = has_boot_w && vector_table_select_bit;
   assign reset_addr_w = boot_reset_w ? boot_section_start : RVM_RESET_ADDR;
   assign irq_addr_w   = rvm_vec_addr(win_num_w, wide_w, reloc_w, boot_section_start);

   assign fetch_valid = (state_q == RVM_ST_RESET) || (state_q == RVM_ST_IRQ);
   assign done_w      = fetch_valid && fetch_ready;
   // A new request is only looked at once the previous vector has been taken
   assign take_w      = (state_q == RVM_ST_IDLE) && cpu_int_enable && any_w;

   always_comb begin
      state_d = state_q;
      case (state_q)
         RVM_ST_CAPTURE: begin
            state_d = RVM_ST_RESET;
         end
         RVM_ST_RESET: begin
            if (done_w) begin
               state_d = RVM_ST_IDLE;
            end
         end
         RVM_ST_IDLE: begin
            if (take_w) begin
               state_d = RVM_ST_IRQ;
            end
         end
         RVM_ST_IRQ: begin
            if (done_w) begin
               state_d = RVM_ST_IDLE;
            end
         end
         default: begin
            state_d = RVM_ST_CAPTURE;
         end
      endcase
   end

   // Fuse is caught in the first cycle after release, then held in the address flop
   assign fetch_addr_d = (state_q == RVM_ST_CAPTURE) ? reset_addr_w :
                         take_w                      ? irq_addr_w   :
                                                       fetch_addr_q;
   assign vector_number_d = take_w ? win_num_w :
                            (state_q == RVM_ST_CAPTURE) ? RVM_VEC_RESET : vector_number_q;
   // Winner is latched; a request that drops before the fetch is still serviced
   assign serviced_d = ((state_q == RVM_ST_IRQ) && fetch_ready) ?
                       (RVM_SRC_ONE << (vector_number_q - RVM_VEC_EXT0)) : RVM_SRC_NONE;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= RVM_ST_CAPTURE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_addr_q    <= RVM_RESET_ADDR;
         vector_number_q <= RVM_VEC_RESET;
         serviced_q      <= RVM_SRC_NONE;
      end else begin
         fetch_addr_q    <= fetch_addr_d;
         vector_number_q <= vector_number_d;
         serviced_q      <= serviced_d;
      end
   end

   // Checks on the mapping and its timing
   logic [13:0] slot_words_w;
   logic [13:0] scaled_w;

   assign slot_words_w = wide_w ? RVM_WIDE_WORDS : RVM_NARROW_WORDS;
   assign scaled_w     = {9'h000, win_num_w} * slot_words_w;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence lone_req_s(logic src);
      (state_q == RVM_ST_IDLE) && cpu_int_enable && src && $onehot(req_w);
   endsequence

   property map_p(logic src, logic [4:0] n);
      lone_req_s(src) |=> fetch_valid && (vector_number_q == n);
   endproperty

   sequence reset_caught_s;
      (state_q == RVM_ST_CAPTURE) ##1 (state_q == RVM_ST_RESET);
   endsequence

   reset_addr_a: assert property (
      (state_q == RVM_ST_CAPTURE) && !boot_reset_w |=> fetch_valid && (fetch_addr_q == RVM_RESET_ADDR))
      else $error("reset fetch address not zero");

   ext0_map_a: assert property (map_p(external_request_zero, RVM_VEC_EXT0))
      else $error("external request zero mapped wrong");

   ext1_map_a: assert property (map_p(external_request_one, RVM_VEC_EXT1))
      else $error("external request one mapped wrong");

   pin_map_a: assert property (map_p(pin_change_group_two, RVM_VEC_PC2))
      else $error("pin change group two mapped wrong");

   wdog_map_a: assert property (map_p(watchdog_timeout_source, RVM_VEC_WDOG))
      else $error("watchdog mapped wrong");

   tmr2_map_a: assert property (map_p(timer2_overflow, RVM_VEC_T2OV))
      else $error("timer 2 overflow mapped wrong");

   tmr1_map_a: assert property (map_p(timer1_capture, RVM_VEC_T1CP))
      else $error("timer 1 capture mapped wrong");

   tmr0_map_a: assert property (map_p(timer0_overflow, RVM_VEC_T0OV))
      else $error("timer 0 overflow mapped wrong");

   rxc_map_a: assert property (map_p(usart_rx_done, RVM_VEC_URX))
      else $error("receive complete mapped wrong");

   txc_map_a: assert property (map_p(usart_tx_done, RVM_VEC_UTX))
      else $error("transmit complete mapped wrong");

   store_map_a: assert property (map_p(program_store_ready_source, RVM_VEC_STORE))
      else $error("program store ready mapped wrong");

   pc0_map_a: assert property (map_p(pin_change_group_zero, RVM_VEC_PC0))
      else $error("pin change group zero mapped wrong");

   pc1_map_a: assert property (map_p(pin_change_group_one, RVM_VEC_PC1))
      else $error("pin change group one mapped wrong");

   t2_cmpa_map_a: assert property (map_p(timer2_compare_a, RVM_VEC_T2CA))
      else $error("timer 2 compare a mapped wrong");

   t2_cmpb_map_a: assert property (map_p(timer2_compare_b, RVM_VEC_T2CB))
      else $error("timer 2 compare b mapped wrong");

   t1_cmpa_map_a: assert property (map_p(timer1_compare_a, RVM_VEC_T1CA))
      else $error("timer 1 compare a mapped wrong");

   t1_cmpb_map_a: assert property (map_p(timer1_compare_b, RVM_VEC_T1CB))
      else $error("timer 1 compare b mapped wrong");

   t1_ovf_map_a: assert property (map_p(timer1_overflow, RVM_VEC_T1OV))
      else $error("timer 1 overflow mapped wrong");

   t0_cmpa_map_a: assert property (map_p(timer0_compare_a, RVM_VEC_T0CA))
      else $error("timer 0 compare a mapped wrong");

   t0_cmpb_map_a: assert property (map_p(timer0_compare_b, RVM_VEC_T0CB))
      else $error("timer 0 compare b mapped wrong");

   spi_map_a: assert property (map_p(serial_transfer_done, RVM_VEC_SPI))
      else $error("serial transfer complete mapped wrong");

   txe_map_a: assert property (map_p(usart_tx_empty, RVM_VEC_UDRE))
      else $error("transmit empty mapped wrong");

   conv_map_a: assert property (map_p(converter_done, RVM_VEC_CONV))
      else $error("converter complete mapped wrong");

   nvm_map_a: assert property (map_p(data_nvm_ready_source, RVM_VEC_NVM))
      else $error("data memory ready mapped wrong");

   cmp_map_a: assert property (map_p(comparator_event, RVM_VEC_ACMP))
      else $error("comparator mapped wrong");

   two_wire_map_a: assert property (map_p(two_wire_serial_source, RVM_VEC_TWO_WIRE))
      else $error("two-wire interface mapped wrong");

   slot_scale_a: assert property (
      take_w && !reloc_w |=> fetch_addr_q == $past(scaled_w))
      else $error("vector slot scaling wrong");

   no_reloc_a: assert property (
      (VARIANT == RVM_VAR_SMALL) && fetch_valid |-> fetch_addr_q == {9'h000, vector_number_q})
      else $error("smallest variant relocated");

   boot_reset_a: assert property (
      reset_caught_s and (has_boot_w && (boot_reset_select_fuse == RVM_FUSE_PROGRAMMED)) ##1 1'b1
      |-> fetch_addr_q == $past(boot_section_start))
      else $error("boot reset address not taken");

   boot_base_a: assert property (
      take_w && reloc_w |=> fetch_addr_q == $past(boot_section_start) + $past(scaled_w))
      else $error("relocated vector address wrong");

   lowest_first_a: assert property (
      take_w && req_w[0] |=> vector_number_q == RVM_VEC_EXT0)
      else $error("lowest vector not first");

   fetch_hold_a: assert property (
      fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch_addr_q) [*1])
      else $error("fetch address dropped before taken");

   serviced_pulse_a: assert property (
      (state_q == RVM_ST_IRQ) && fetch_ready |=> $onehot(serviced_q) ##1 (serviced_q == RVM_SRC_NONE))
      else $error("serviced pulse wrong");

endmodule
`default_nettype wire

/* inc/rvm_pkg.sv */
// Constants, state type and address arithmetic for the reset and interrupt vector map
package rvm_pkg;

   localparam int unsigned RVM_ADDR_W = 14;
   localparam int unsigned RVM_NUM_W  = 5;
   localparam int unsigned RVM_SRC_N  = 25;

   // Table position of each event; the slot address is this number times the slot size
   localparam logic [4:0] RVM_VEC_RESET = 5'h00;
   localparam logic [4:0] RVM_VEC_EXT0  = 5'h01;
   localparam logic [4:0] RVM_VEC_EXT1  = 5'h02;
   localparam logic [4:0] RVM_VEC_PC0   = 5'h03;
   localparam logic [4:0] RVM_VEC_PC1   = 5'h04;
   localparam logic [4:0] RVM_VEC_PC2   = 5'h05;
   localparam logic [4:0] RVM_VEC_WDOG  = 5'h06;
   localparam logic [4:0] RVM_VEC_T2CA  = 5'h07;
   localparam logic [4:0] RVM_VEC_T2CB  = 5'h08;
   localparam logic [4:0] RVM_VEC_T2OV  = 5'h09;
   localparam logic [4:0] RVM_VEC_T1CP  = 5'h0A;
   localparam logic [4:0] RVM_VEC_T1CA  = 5'h0B;
   localparam logic [4:0] RVM_VEC_T1CB  = 5'h0C;
   localparam logic [4:0] RVM_VEC_T1OV  = 5'h0D;
   localparam logic [4:0] RVM_VEC_T0CA  = 5'h0E;
   localparam logic [4:0] RVM_VEC_T0CB  = 5'h0F;
   localparam logic [4:0] RVM_VEC_T0OV  = 5'h10;
   localparam logic [4:0] RVM_VEC_SPI   = 5'h11;
   localparam logic [4:0] RVM_VEC_URX   = 5'h12;
   localparam logic [4:0] RVM_VEC_UDRE  = 5'h13;
   localparam logic [4:0] RVM_VEC_UTX   = 5'h14;
   localparam logic [4:0] RVM_VEC_CONV  = 5'h15;
   localparam logic [4:0] RVM_VEC_NVM   = 5'h16;
   localparam logic [4:0] RVM_VEC_ACMP  = 5'h17;
   localparam logic [4:0] RVM_VEC_TWO_WIRE = 5'h18;
   localparam logic [4:0] RVM_VEC_STORE    = 5'h19;

   localparam logic [13:0] RVM_RESET_ADDR     = 14'h0000;
   localparam logic [13:0] RVM_WIDE_WORDS     = 14'h0002;
   localparam logic [13:0] RVM_NARROW_WORDS   = 14'h0001;
   localparam logic [24:0] RVM_SRC_ONE        = 25'h0000001;
   localparam logic [24:0] RVM_SRC_NONE       = 25'h0000000;

   // Memory variants, smallest first
   localparam logic [1:0] RVM_VAR_SMALL    = 2'h0;
   localparam logic [1:0] RVM_VAR_WIDE_MIN = 2'h2;
   localparam logic [1:0] RVM_VAR_LARGEST  = 2'h3;

   // Fuse reads zero when programmed
   localparam logic RVM_FUSE_PROGRAMMED = 1'b0;

   typedef enum logic [3:0] {
      RVM_ST_CAPTURE = 4'h1,
      RVM_ST_RESET   = 4'h2,
      RVM_ST_IDLE    = 4'h4,
      RVM_ST_IRQ     = 4'h8
   } rvm_state_e;

   function automatic logic [13:0] rvm_vec_addr(input logic [4:0]  num,
                                                input logic        wide,
                                                input logic        reloc,
                                                input logic [13:0] base);
      logic [13:0] slot;
      slot = wide ? {8'h00, num, 1'b0} : {9'h000, num};
      rvm_vec_addr = reloc ? base + slot : slot;
   endfunction

endpackage

/* logic/rvm_prio_enc.sv */
// Lowest-number-first selection among pending interrupt requests
`timescale 1ns/100ps
`default_nettype none
module rvm_prio_enc
   import rvm_pkg::*;
(
   input  wire logic [24:0] req,
   output logic             any,
   output logic [4:0]       num
);

   assign any = |req;

   // Scan downward so the lowest set bit is the last one written
   always_comb begin
      num = RVM_VEC_RESET;
      for (int i = RVM_SRC_N - 1; i >= 0; i--) begin
         if (req[i]) begin
            num = 5'(i) + RVM_VEC_EXT0;
         end
      end
   end

endmodule
`default_nettype wire

/* sim/rvm_core_model.sv */
// Core fetch model that takes offered vector addresses after a chosen wait
`timescale 1ns/100ps
`default_nettype none
module rvm_core_model (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        fetch_valid,
   input  wire logic [13:0] fetch_addr,
   input  wire logic [3:0]  wait_cycles,
   output logic             fetch_ready,
   output logic [13:0]      taken_addr,
   output logic [13:0]      taken_cnt
);
   logic [3:0] wait_q;
   // Ready is held from the edge it rises until the edge that takes the fetch
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_ready <= 1'b0;
         wait_q      <= 4'h0;
         taken_addr  <= 14'h0000;
         taken_cnt   <= 14'h0000;
      end else if (fetch_valid && fetch_ready) begin
         fetch_ready <= 1'b0;
         wait_q      <= 4'h0;
         taken_addr  <= fetch_addr;
         taken_cnt   <= taken_cnt + 14'h0001;
      end else if (fetch_valid) begin
         if (wait_q >= wait_cycles) begin
            fetch_ready <= 1'b1;
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* sim/test_reset_interrupt_vector_map.sv */
// Testbench for the vector map: largest and smallest variants side by side
`timescale 1ns/100ps
`default_nettype none
module test_reset_interrupt_vector_map;
   import rvm_pkg::*;
   logic             clk;
   logic             arst_n;
   logic [24:0]      req;
   logic             int_en;
   logic             sel_bit;
   logic             fuse;
   logic [13:0]      base;
   logic [3:0]       dly;
   logic [4:0]       seen;
   wire logic        fv  [2];
   wire logic        rdy [2];
   wire logic [13:0] fa  [2];
   wire logic [13:0] ta  [2];
   wire logic [13:0] tc  [2];
   wire logic [4:0]  vn  [2];
   wire logic [24:0] ack [2];
   int               failures = 0;
   int               total_checks = 0;
   int               cycles = 0;

   // Index 0 is the largest variant, index 1 the smallest
   for (genvar v = 0; v < 2; v++) begin : g_end
      rvm_vector_map #(.VARIANT((v == 0) ? 2'h3 : 2'h0)) rvm_vector_map_inst (
         .clk(clk), .arst_n(arst_n), .external_request_zero(req[0]), .external_request_one(req[1]),
         .pin_change_group_zero(req[2]), .pin_change_group_one(req[3]), .pin_change_group_two(req[4]),
         .watchdog_timeout_source(req[5]), .timer2_compare_a(req[6]), .timer2_compare_b(req[7]),
         .timer2_overflow(req[8]), .timer1_capture(req[9]), .timer1_compare_a(req[10]),
         .timer1_compare_b(req[11]), .timer1_overflow(req[12]), .timer0_compare_a(req[13]),
         .timer0_compare_b(req[14]), .timer0_overflow(req[15]), .serial_transfer_done(req[16]),
         .usart_rx_done(req[17]), .usart_tx_empty(req[18]), .usart_tx_done(req[19]),
         .converter_done(req[20]), .data_nvm_ready_source(req[21]), .comparator_event(req[22]),
         .two_wire_serial_source(req[23]), .program_store_ready_source(req[24]),
         .cpu_int_enable(int_en), .vector_table_select_bit(sel_bit), .boot_reset_select_fuse(fuse),
         .boot_section_start(base), .fetch_ready(rdy[v]), .fetch_valid(fv[v]), .fetch_addr_q(fa[v]),
         .vector_number_q(vn[v]), .serviced_q(ack[v]));
      rvm_core_model rvm_core_model_inst (
         .clk(clk), .arst_n(arst_n), .fetch_valid(fv[v]), .fetch_addr(fa[v]), .wait_cycles(dly),
         .fetch_ready(rdy[v]), .taken_addr(ta[v]), .taken_cnt(tc[v]));
   end

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Expected slot address worked out independently of the design
   function automatic logic [13:0] exp_vec(input int n, input int i);
      logic [13:0] slot;
      slot = (i == 0) ? 14'(2 * n) : 14'(n);
      exp_vec = (sel_bit && i == 0) ? base + slot : slot;
   endfunction

   task automatic check_word(input logic [13:0] got, input logic [13:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_ack(input logic [24:0] got, input logic [24:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic give_verdict();
      if (failures == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic reset_run(input logic f, input logic [13:0] b);
      arst_n = 1'b0;
      fuse = f;
      base = b;
      req = 25'h0000000;
      tick(3);
      arst_n = 1'b1;
      for (int k = 0; k < 20 && tc[0] !== 14'h0001; k++) tick(1);
      for (int i = 0; i < 2; i++) check_word(ta[i], (f == 1'b0 && i == 0) ? b : 14'h0000);
   endtask

   // Waits for the dispatch of source n, then drops only that request
   task automatic serve(input int n);
      logic ok;
      ok = 1'b0;
      seen = 5'h00;
      for (int k = 0; k < 40 && !ok; k++) begin
         tick(1);
         if (fv[0] === 1'b1) seen = vn[0];
         ok = (ack[0] !== 25'h0000000);
      end
      req = req & ~(25'h0000001 << (n - 1));
      check_word({9'h000, seen}, 14'(n));
      for (int i = 0; i < 2; i++) begin
         check_ack(ack[i], 25'h0000001 << (n - 1));
         check_word({9'h000, vn[i]}, 14'(n));
         check_word({13'h0000, fv[i]}, 14'h0000);
         check_word(ta[i], exp_vec(n, i));
      end
      tick(1);
      check_ack(ack[0], 25'h0000000);
   endtask

   task automatic table_walk(input logic s);
      sel_bit = s;
      for (int n = 1; n <= 25; n++) begin
         dly = 4'(n % 3);
         req = 25'h0000001 << (n - 1);
         serve(n);
      end
   endtask

   // Three pending at once: lowest table position goes first
   task automatic priority_pick();
      req = 25'h1000044;
      serve(3);
      serve(7);
      serve(25);
   endtask

   // Disabled requests are held off, not lost
   task automatic refuse_disabled();
      logic [13:0] tc_start;
      tc_start = tc[0];
      int_en = 1'b0;
      req = 25'h0000020;
      tick(8);
      check_word(tc[0], tc_start);
      int_en = 1'b1;
      serve(6);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         give_verdict();
      end
   end

   initial begin
      arst_n = 1'b0;
      req = 25'h0000000;
      int_en = 1'b1;
      sel_bit = 1'b0;
      fuse = 1'b1;
      base = 14'h3800;
      dly = 4'h0;
      seen = 5'h00;
      reset_run(1'b1, 14'h3800);
      table_walk(1'b0);
      table_walk(1'b1);
      priority_pick();
      refuse_disabled();
      reset_run(1'b0, 14'h1F00);
      table_walk(1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
